//--- design/etc_pkg.sv
// constants shared by the three-channel 8-bit timer block
// assumes a word-addressed classic wishbone slave, byte data in bits 7:0
`default_nettype none

package etc_pkg;

  // channel count and counter width
  localparam int NUM_CH = 3;
  localparam int CNT_W = 8;

  // register indices; byte address is four times the index
  localparam logic [15:0] MODE_IDX_BASE = 16'hFF53;
  localparam logic [15:0] MODE_IDX_STEP = 16'h0004;
  localparam logic [15:0] CMP_IDX_BASE = 16'hFF60;
  localparam logic [15:0] CNT_IDX_BASE = 16'hFF64;
  localparam logic [15:0] IRQ_STAT_IDX = 16'hFF68;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hFF69;

  // mode register fields
  localparam int RUN_BIT = 7;
  localparam int CLKSEL_HI = 2;
  localparam int CLKSEL_LO = 1;
  localparam int OUTEN_BIT = 0;

  // writable bits of the mode registers; others read zero
  localparam logic [7:0] MODE_WMASK_EVT = 8'h86;
  localparam logic [7:0] MODE_WMASK_SQW = 8'h87;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;

  // prescaler width and log2 of the fast and slow taps per channel
  localparam int PRESC_W = 9;
  localparam int FAST_LOG [NUM_CH] = '{6, 4, 3};
  localparam int SLOW_LOG [NUM_CH] = '{9, 8, 7};

  // count clock choices
  typedef enum logic [1:0] {
    CS_FAST = 2'h0,
    CS_SLOW = 2'h1,
    CS_RISE = 2'h2,
    CS_FALL = 2'h3
  } etc_clksel_e;

endpackage

`default_nettype wire

//--- design/etc_timer_counters.sv
// three 8-bit interval timers with event counting and square-wave output
// assumes mclk free running, event and sub clock pins asynchronous to it
`default_nettype none

module etc_timer_counters
  import etc_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire  logic              mclk,
  input  wire  logic              resetn,
  // classic wishbone slave
  input  wire  logic              cyc_i,
  input  wire  logic              stb_i,
  input  wire  logic              we_i,
  input  wire  logic [ADDR_W-1:0] adr_i,
  input  wire  logic [3:0]        sel_i,
  input  wire  logic [31:0]       dat_i,
  output var   logic [31:0]       dat_o,
  output var   logic              ack_o,
  // external pins
  input  wire  logic              eventInputZero,
  input  wire  logic              eventInputOne,
  input  wire  logic              subClock,
  output var   logic              squareOutput,
  // interrupt
  output var   logic              matchIrq
);

  // elaboration check: indices need 16 bits above the byte lanes
  if (ADDR_W < 18) begin : g_chk
    $error("etc_timer_counters: ADDR_W must be at least 18");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]         modeReg [NUM_CH];   // mode registers
  logic [7:0]         next_mode [NUM_CH];
  logic [7:0]         cmpReg [NUM_CH];    // compare values
  logic [7:0]         next_cmp [NUM_CH];
  logic [7:0]         cnt [NUM_CH];       // counters
  logic [7:0]         next_cnt [NUM_CH];
  logic [NUM_CH-1:0]  irqStat;            // sticky match flags
  logic [NUM_CH-1:0]  next_stat;
  logic [NUM_CH-1:0]  irqMask;            // interrupt enables
  logic [NUM_CH-1:0]  next_mask;
  logic [NUM_CH-1:0]  statClr;            // write-one-to-clear strobe
  logic [NUM_CH-1:0]  tick;               // count clock pulse
  logic [NUM_CH-1:0]  match;              // compare match this cycle
  logic [PRESC_W-1:0] presc;              // free running prescaler
  logic               next_ack;
  logic [31:0]        next_dat;
  logic               next_sq;
  logic               next_irq;
  logic               wrEn;               // write takes effect now
  logic [15:0]        wIdx;               // word index of request
  logic [NUM_CH-1:0]  syncA;              // first sync stage only
  logic [NUM_CH-1:0]  syncB;              // second sync stage
  logic [NUM_CH-1:0]  syncC;              // edge history
  logic [NUM_CH-1:0]  edgeRise;
  logic [NUM_CH-1:0]  edgeFall;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; sub clock rides in slot 2
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
      presc <= '0;
    end else begin
      syncA <= {subClock, eventInputOne, eventInputZero};
      syncB <= syncA;
      syncC <= syncB;
      presc <= presc + 1'b1;
    end
  end

  // edges seen only from the second stage onward
  assign edgeRise = syncB & ~syncC;
  assign edgeFall = ~syncB & syncC;

  ////////////////////////////////////////////////////////////////////////
  // count clock selection per channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      unique case (etc_clksel_e'(modeReg[c][CLKSEL_HI:CLKSEL_LO]))
        CS_FAST: tick[c] = &(presc | ~((PRESC_W)'((1 << FAST_LOG[c]) - 1)));
        CS_SLOW: tick[c] = &(presc | ~((PRESC_W)'((1 << SLOW_LOG[c]) - 1)));
        // slot 2 rise is the sub clock
        CS_RISE: tick[c] = edgeRise[c];
        // falling edge events not on channel 2
        CS_FALL: tick[c] = (c < 2) ? edgeFall[c] : 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, then ack for one cycle
  assign wIdx = adr_i[17:2];
  // write lands on the edge where ack is seen high
  assign wrEn = cyc_i & stb_i & we_i & ack_o & sel_i[0]
                & (adr_i[ADDR_W-1:2] == (ADDR_W-2)'(wIdx));

  always_comb begin
    next_ack  = cyc_i & stb_i & ~ack_o;
    next_dat  = 32'h0000_0000;
    next_mode = modeReg;
    next_cmp  = cmpReg;
    next_mask = irqMask;
    statClr   = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // mode register
      if (wIdx == MODE_IDX_BASE + 16'(c) * MODE_IDX_STEP) begin
        next_dat[7:0] = modeReg[c];
        // fixed zero bits are masked away
        if (wrEn) begin
          next_mode[c] = dat_i[7:0]
                         & ((c == 2) ? MODE_WMASK_SQW : MODE_WMASK_EVT);
        end
      end
      // compare register
      if (wIdx == CMP_IDX_BASE + 16'(c)) begin
        next_dat[7:0] = cmpReg[c];
        if (wrEn) begin
          next_cmp[c] = dat_i[7:0];
        end
      end
      if (wIdx == CNT_IDX_BASE + 16'(c)) begin
        next_dat[7:0] = cnt[c];
      end
    end
    // interrupt status and mask
    if (wIdx == IRQ_STAT_IDX) begin
      next_dat[NUM_CH-1:0] = irqStat;
      if (wrEn) begin
        statClr = dat_i[NUM_CH-1:0];
      end
    end
    if (wIdx == IRQ_MASK_IDX) begin
      next_dat[NUM_CH-1:0] = irqMask;
      if (wrEn) begin
        next_mask = dat_i[NUM_CH-1:0];
      end
    end
    // unmapped reads return zero, data only beside ack
    if (!next_ack) begin
      next_dat = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters, compare, square output and interrupt next state
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      match[c] = 1'b0;
      if (!modeReg[c][RUN_BIT]) begin
        next_cnt[c] = CNT_RST;
      end else if (tick[c]) begin
        if (cnt[c] == cmpReg[c]) begin
          next_cnt[c] = CNT_RST;
          match[c] = 1'b1;
        end else begin
          next_cnt[c] = cnt[c] + 8'h01;
        end
      end else begin
        next_cnt[c] = cnt[c];
      end
    end
    if (!modeReg[2][OUTEN_BIT]) begin
      next_sq = 1'b0;
    end else begin
      next_sq = squareOutput ^ match[2];
    end
    // set wins over a same-cycle clear
    next_stat = (irqStat & ~statClr) | match;
    next_irq  = |(next_stat & irqMask);
  end

  // registers of the bus, channel and interrupt groups
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_o        <= 1'b0;
      dat_o        <= 32'h0000_0000;
      squareOutput <= 1'b0;
      matchIrq     <= 1'b0;
      irqStat      <= '0;
      irqMask      <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        modeReg[c] <= MODE_RST;
        cmpReg[c]  <= CMP_RST;
        cnt[c]     <= CNT_RST;
      end
    end else begin
      ack_o        <= next_ack;
      dat_o        <= next_dat;
      // channel 2 alone drives the pin
      squareOutput <= next_sq;
      matchIrq     <= next_irq;
      irqStat      <= next_stat;
      irqMask      <= next_mask;
      modeReg      <= next_mode;
      cmpReg       <= next_cmp;
      cnt          <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_stop_clears;
    !modeReg[0][RUN_BIT] |=> cnt[0] == CNT_RST;
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("stopped channel 0 counter not zero");

  property p_match_wraps;
    modeReg[0][RUN_BIT] && tick[0] && cnt[0] == cmpReg[0]
      |=> cnt[0] == CNT_RST && irqStat[0];
  endproperty
  a_match_wraps: assert property (p_match_wraps)
    else $error("match did not clear counter and flag");

  property p_count_up;
    modeReg[0][RUN_BIT] && tick[0] && cnt[0] != cmpReg[0]
      |=> cnt[0] == $past(cnt[0]) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not step by one");

  property p_hold_idle;
    modeReg[1][RUN_BIT] && !tick[1] |=> $stable(cnt[1]);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("counter moved without a count pulse");

  property p_no_fall_ch2;
    modeReg[2][CLKSEL_HI:CLKSEL_LO] == CS_FALL |-> !tick[2];
  endproperty
  a_no_fall_ch2: assert property (p_no_fall_ch2)
    else $error("channel 2 counted on a prohibited source");

  property p_event_rise;
    modeReg[0][CLKSEL_HI:CLKSEL_LO] == CS_RISE
      ##0 $rose(syncB[0]) |-> tick[0];
  endproperty
  a_event_rise: assert property (p_event_rise)
    else $error("event rise not counted on channel 0");

  property p_fast_tap;
    modeReg[0][CLKSEL_HI:CLKSEL_LO] == CS_FAST && tick[0]
      |-> presc[5:0] == 6'h3F ##1 !tick[0] [*8];
  endproperty
  a_fast_tap: assert property (p_fast_tap)
    else $error("channel 0 fast tap wrong period");

  property p_ch1_slow;
    modeReg[1][CLKSEL_HI:CLKSEL_LO] == CS_SLOW && tick[1]
      |-> presc[7:0] == 8'hFF;
  endproperty
  a_ch1_slow: assert property (p_ch1_slow)
    else $error("channel 1 slow tap wrong");

  property p_ch2_fast;
    modeReg[2][CLKSEL_HI:CLKSEL_LO] == CS_FAST && tick[2]
      |-> presc[2:0] == 3'h7;
  endproperty
  a_ch2_fast: assert property (p_ch2_fast)
    else $error("channel 2 fast tap wrong");

  property p_square_toggle;
    match[2] && modeReg[2][OUTEN_BIT]
      |=> squareOutput != $past(squareOutput);
  endproperty
  a_square_toggle: assert property (p_square_toggle)
    else $error("square output did not toggle on match");

  property p_mode_zeros;
    modeReg[0][6:3] == 4'h0 && !modeReg[0][0];
  endproperty
  a_mode_zeros: assert property (p_mode_zeros)
    else $error("fixed zero bits of mode 0 set");

  property p_cmp_write;
    wrEn && wIdx == CMP_IDX_BASE |=> cmpReg[0] == $past(dat_i[7:0]);
  endproperty
  a_cmp_write: assert property (p_cmp_write)
    else $error("compare write not stored");

  property p_irq_level;
    matchIrq == |(irqStat & $past(irqMask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not raised for unmasked flag");

endmodule

`default_nettype wire

//--- test/etc_timer_counters_bench.sv
// bench for the three-channel 8-bit timer block: bus, pins, interrupt
// assumes the block answers each wishbone request with a one-cycle ack
`default_nettype none

module etc_timer_counters_bench
  import etc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic        mclk   = 1'b0;
  logic        resetn = 1'b0;
  logic        cycI   = 1'b0;
  logic        stbI   = 1'b0;
  logic        weI    = 1'b0;
  logic [17:0] adrI   = 18'h00000;
  logic [31:0] datI   = 32'h00000000;
  logic [3:0]  selI   = 4'hF;   // byte enables
  logic [2:0]  pins   = 3'h0;   // ev0, ev1, sub clock
  logic [31:0] datO;
  logic        ackO;
  logic        sqOut;
  logic        irq;
  int          cyc    = 0;      // free cycle count for interval timing
  int          fails  = 0;
  int          checkCount = 0;

  // 8 ns period
  always #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  etc_timer_counters u_dut (
    .mclk(mclk), .resetn(resetn), .cyc_i(cycI), .stb_i(stbI),
    .we_i(weI), .adr_i(adrI), .sel_i(selI), .dat_i(datI),
    .dat_o(datO), .ack_o(ackO), .eventInputZero(pins[0]),
    .eventInputOne(pins[1]), .subClock(pins[2]),
    .squareOutput(sqOut), .matchIrq(irq)
  );

  //////////////////////////////////////////////////////////////////////
  // verdict, compare and bus helpers
  task automatic final_report;
    if (fails == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    fails++;
    final_report();
  endtask

  // one classic cycle; held until ack, then one idle cycle
  task automatic wb(input logic [15:0] idx, input logic w,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI  <= w;
    adrI <= {idx, 2'b00};
    datI <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ackO !== 1'b1 && n < 16);
    if (n >= 16) timeout();
    q = datO[7:0];
    cycI <= 1'b0;
    stbI <= 1'b0;
    weI  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(idx, 1'b1, d, q);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] q;
    wb(idx, 1'b0, 8'h00, q);
    chk({24'h000000, q}, {24'h000000, e});
  endtask

  // bounded waits; sq=1 waits for an output change, else irq high
  task automatic wait_ev(input bit sq, output int t);
    logic s;
    int   n;
    s = sqOut;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((sq ? sqOut === s : irq !== 1'b1) && n < 1100);
    if (n >= 1100) timeout();
    t = cyc;
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rd(MODE_IDX_BASE, MODE_RST);
    rd(CNT_IDX_BASE + 16'h0002, CNT_RST);
    wr(MODE_IDX_BASE, 8'hFF);
    rd(MODE_IDX_BASE, 8'h86);
    wr(MODE_IDX_BASE, 8'h00);
    wr(MODE_IDX_BASE + 16'h0008, 8'hFF);
    rd(MODE_IDX_BASE + 16'h0008, 8'h87);
    wr(MODE_IDX_BASE + 16'h0008, 8'h00);
    wr(CMP_IDX_BASE + 16'h0001, 8'hFF);
    rd(CMP_IDX_BASE + 16'h0001, 8'hFF);
    // a write without the low byte lane is ignored
    selI <= 4'h0;
    wr(CMP_IDX_BASE + 16'h0001, 8'h12);
    selI <= 4'hF;
    rd(CMP_IDX_BASE + 16'h0001, 8'hFF);
    wr(CNT_IDX_BASE, 8'h55);
    rd(CNT_IDX_BASE, 8'h00);
    rd(16'hFF70, 8'h00);
  endtask

  // stop and select, set compare, enable, pulse, then stop again
  task automatic evt(input int ch, input logic [7:0] m, input int n);
    logic [15:0] mi;
    mi = MODE_IDX_BASE + 16'(ch) * MODE_IDX_STEP;
    wr(mi, m & 8'h7F);
    wr(CMP_IDX_BASE + 16'(ch), 8'hFF);
    wr(mi, m);
    repeat (n) begin
      pins[ch] <= 1'b1;
      repeat (4) @(posedge mclk);
      pins[ch] <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    rd(CNT_IDX_BASE + 16'(ch), 8'(n));
    wr(mi, 8'h00);
    rd(CNT_IDX_BASE + 16'(ch), 8'h00);
  endtask

  task automatic t_interval;
    int t0;
    int t1;
    wr(IRQ_MASK_IDX, 8'h01);
    wr(MODE_IDX_BASE, 8'h00);
    wr(CMP_IDX_BASE, 8'h02);
    wr(MODE_IDX_BASE, 8'h80);
    wait_ev(1'b0, t0);
    rd(IRQ_STAT_IDX, 8'h01);
    wr(IRQ_STAT_IDX, 8'h01);
    wait_ev(1'b0, t1);
    chk(t1 - t0, 3 * 64);
    // masked: status stays, output drops
    wr(IRQ_MASK_IDX, 8'h00);
    @(negedge mclk);
    chk(irq, 1'b0);
    @(posedge mclk);
    wr(IRQ_MASK_IDX, 8'h01);
    @(negedge mclk);
    chk(irq, 1'b1);
    @(posedge mclk);
    wr(MODE_IDX_BASE, 8'h00);
    wr(IRQ_STAT_IDX, 8'h07);
    @(negedge mclk);
    chk(irq, 1'b0);
    @(posedge mclk);
    rd(CNT_IDX_BASE, 8'h00);
  endtask

  // internal tap interval: compare c gives c+1 tap periods
  task automatic t_tap(input int ch, input logic [7:0] m,
                       input logic [7:0] c, input int per);
    int          t0;
    int          t1;
    logic [15:0] mi;
    mi = MODE_IDX_BASE + 16'(ch) * MODE_IDX_STEP;
    wr(IRQ_MASK_IDX, 8'(1 << ch));
    wr(mi, m);
    wr(CMP_IDX_BASE + 16'(ch), c);
    wr(mi, m | 8'h80);
    wait_ev(1'b0, t0);
    wr(IRQ_STAT_IDX, 8'h07);
    wait_ev(1'b0, t1);
    chk(t1 - t0, per);
    wr(mi, 8'h00);
    wr(IRQ_STAT_IDX, 8'h07);
  endtask

  task automatic t_square;
    int t0;
    int t1;
    int t2;
    wr(MODE_IDX_BASE + 16'h0008, 8'h01);
    wr(CMP_IDX_BASE + 16'h0002, 8'h03);
    wr(MODE_IDX_BASE + 16'h0008, 8'h81);
    wait_ev(1'b1, t0);
    wait_ev(1'b1, t1);
    wait_ev(1'b1, t2);
    chk(t1 - t0, 4 * 8);
    chk(t2 - t1, 4 * 8);
    wr(MODE_IDX_BASE + 16'h0008, 8'h00);
    @(negedge mclk);
    chk(sqOut, 1'b0);
    @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence: reset for five cycles, then every scenario
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk(irq, 1'b0);
    t_regs();
    evt(0, 8'h84, 5);
    evt(0, 8'h86, 3);
    evt(1, 8'h84, 4);
    evt(1, 8'h86, 2);
    evt(2, 8'h84, 3);
    t_interval();
    t_tap(0, 8'h02, 8'h00, 512);
    t_tap(1, 8'h00, 8'h07, 8 * 16);
    t_tap(1, 8'h02, 8'h00, 256);
    t_tap(2, 8'h02, 8'h00, 128);
    t_square();
    final_report();
  end
endmodule

`default_nettype wire
